/* File: design/adcc_params.svh */
// offsets, field positions, reset values and timing counts of the converter control block
// assumes: included by the design files by bare name, 32-bit apb data, byte addresses
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
`define ADCC_OFF_MAIN 8'h00
`define ADCC_OFF_PORT 8'h04
`define ADCC_OFF_TIMING 8'h08
`define ADCC_OFF_RES_HI 8'h0C
`define ADCC_OFF_RES_LO 8'h10
`define ADCC_OFF_FLAG 8'h14
`define ADCC_ON_BIT 0
`define ADCC_GO_BIT 1
`define ADCC_CHAN_LSB 2
`define ADCC_NREF_BIT 5
`define ADCC_PREF_BIT 4
`define ADCC_ALIGN_BIT 7
`define ADCC_ACQ_LSB 3
`define ADCC_FLAG_BIT 0
`define ADCC_PCFG_FUSE_SET 4'h0
`define ADCC_PCFG_FUSE_CLR 4'h7
`define ADCC_INSTR_CYCLES 4
`endif

/* File: design/adcc_pkg.sv */
// types shared by the converter control modules
// assumes: compiled before every other design file
package adcc_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_RC_DLY, ST_ACQ, ST_CONV} adcc_state_e;
   typedef logic [9:0] adcc_result_t;
endpackage

/* File: design/adcc_sar_if.sv */
// link between the sequencer and the successive-approximation engine
// assumes: both ends run on pclk
`timescale 1ns/1ns
interface adcc_sar_if;
   logic tad;
   logic start;
   logic abort;
   logic cmp_above;
   logic done;
   logic [9:0] dac_code;
   logic [9:0] result;
   modport ctl (output tad, start, abort, cmp_above, input dac_code, done, result);
   modport sar (input tad, start, abort, cmp_above, output dac_code, done, result);
endinterface

/* File: design/adcc_tad_gen.sv */
// conversion bit period generator: system clock divider or internal rc tick
// assumes: rc_tick is a one-cycle pulse synchronous to pclk
`timescale 1ns/1ns
module adcc_tad_gen
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [2:0] clk_sel,
   input wire logic rc_tick,
   output logic tad
);
   logic [6:0] count;
   logic [6:0] div;
   logic use_rc;

   function automatic logic [6:0] div_of(input logic [2:0] sel);
      case (sel)
         3'h0: div_of = 7'h02;
         3'h1: div_of = 7'h08;
         3'h2: div_of = 7'h20;
         3'h4: div_of = 7'h04;
         3'h5: div_of = 7'h10;
         3'h6: div_of = 7'h40;
         default: div_of = 7'h00;
      endcase
   endfunction

   assign div = div_of(clk_sel);
   assign use_rc = (clk_sel[1:0] == 2'h3);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 7'h00;
      end else if (!enable || use_rc || count == div - 7'h01) begin
         count <= 7'h00;
      end else begin
         count <= count + 7'h01;
      end
   end

   assign tad = enable && (use_rc ? rc_tick : (count == div - 7'h01));

   a_tad_div_four: assert property (
      @(posedge pclk) disable iff (!presetn || !enable || clk_sel != 3'h4)
      tad |=> !tad [*3] ##1 tad)
      else $error("divide-by-4 bit period wrong");
endmodule

/* File: design/adcc_sar.sv */
// successive-approximation engine: one result bit per conversion bit period
// assumes: cmp_above is high while the input is at or above the dac code
`timescale 1ns/1ns
module adcc_sar
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   adcc_sar_if.sar conv
);
   adcc_result_t trial;
   logic [3:0] bit_idx;
   logic active;
   adcc_result_t kept;

   function automatic adcc_result_t one_hot(input logic [3:0] i);
      one_hot = 10'h001 << i;
   endfunction

   assign kept = conv.cmp_above ? trial : (trial & ~one_hot(bit_idx));
   assign conv.dac_code = trial;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
         trial <= 10'h000;
         bit_idx <= 4'h0;
      end else if (conv.abort) begin
         active <= 1'b0;
      end else if (conv.start) begin
         active <= 1'b1;
         trial <= 10'h200;
         bit_idx <= 4'h9;
      end else if (active && conv.tad) begin
         if (bit_idx == 4'h0) begin
            active <= 1'b0;
            trial <= kept;
         end else begin
            trial <= kept | one_hot(bit_idx - 4'h1);
            bit_idx <= bit_idx - 4'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv.done <= 1'b0;
         conv.result <= 10'h000;
      end else begin
         conv.done <= !conv.abort && active && conv.tad && bit_idx == 4'h0;
         if (!conv.abort && active && conv.tad && bit_idx == 4'h0) begin
            conv.result <= kept;
         end
      end
   end
endmodule

/* File: design/adcc_ctrl.sv */
// converter control top: apb registers, acquisition and conversion sequencer
// assumes: apb master on pclk, analog comparator and dac outside this block
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "adcc_params.svh"

module adcc_ctrl
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic portb_analog_default_fuse,
   input wire logic rc_tick,
   input wire logic cmp_above,
   output logic [9:0] dac_code,
   output logic converter_enable,
   output logic sampling,
   output logic [3:0] channel_select,
   output logic neg_ref_select,
   output logic pos_ref_select,
   output logic [12:0] analog_pin_mask,
   output logic conv_complete_flag
);
   adcc_sar_if conv ();
   adcc_state_e state;
   logic converter_on;
   logic [3:0] pin_analog_config;
   logic result_align;
   logic [2:0] acq_time_select;
   logic [2:0] conv_clock_select;
   logic [7:0] result_high;
   logic [7:0] result_low;
   logic por_loaded;
   logic [4:0] acq_cnt;
   logic [2:0] dly_cnt;
   logic wr;
   logic rd_setup;
   logic go_req;
   logic busy;
   logic rc_sel;

   function automatic logic [4:0] acq_periods(input logic [2:0] code);
      case (code)
         3'h7: acq_periods = 5'h14;
         3'h6: acq_periods = 5'h10;
         3'h5: acq_periods = 5'h0C;
         3'h4: acq_periods = 5'h08;
         3'h3: acq_periods = 5'h06;
         3'h2: acq_periods = 5'h04;
         3'h1: acq_periods = 5'h02;
         default: acq_periods = 5'h00;
      endcase
   endfunction

   function automatic logic [12:0] pin_mask(input logic [3:0] code);
      logic [3:0] digital;
      digital = (code <= 4'h2) ? 4'h0 : code - 4'h2;
      pin_mask = 13'h1FFF >> digital;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `ADCC_OFF_MAIN) || (a == `ADCC_OFF_PORT) || (a == `ADCC_OFF_TIMING)
         || (a == `ADCC_OFF_RES_HI) || (a == `ADCC_OFF_RES_LO) || (a == `ADCC_OFF_FLAG);
   endfunction

   // apb handshake: zero wait states
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr = psel && penable && pwrite && mapped(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   // go only starts once the converter is already on
   assign go_req = wr && paddr == `ADCC_OFF_MAIN && pwdata[`ADCC_GO_BIT]
      && pwdata[`ADCC_ON_BIT] && converter_on && state == ST_IDLE;
   assign busy = (state != ST_IDLE);
   assign rc_sel = (conv_clock_select[1:0] == 2'h3);

   // main control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_on <= 1'b0;
         channel_select <= 4'h0;
      end else if (wr && paddr == `ADCC_OFF_MAIN) begin
         converter_on <= pwdata[`ADCC_ON_BIT];
         channel_select <= pwdata[`ADCC_CHAN_LSB +: 4];
      end
   end

   // port configuration; pin field taken from the fuse once after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_loaded <= 1'b0;
         neg_ref_select <= 1'b0;
         pos_ref_select <= 1'b0;
         pin_analog_config <= `ADCC_PCFG_FUSE_SET;
      end else if (!por_loaded) begin
         por_loaded <= 1'b1;
         pin_analog_config <= portb_analog_default_fuse ? `ADCC_PCFG_FUSE_SET
            : `ADCC_PCFG_FUSE_CLR;
      end else if (wr && paddr == `ADCC_OFF_PORT) begin
         neg_ref_select <= pwdata[`ADCC_NREF_BIT];
         pos_ref_select <= pwdata[`ADCC_PREF_BIT];
         pin_analog_config <= pwdata[3:0];
      end
   end

   assign analog_pin_mask = pin_mask(pin_analog_config);

   // timing configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_align <= 1'b0;
         acq_time_select <= 3'h0;
         conv_clock_select <= 3'h0;
      end else if (wr && paddr == `ADCC_OFF_TIMING) begin
         result_align <= pwdata[`ADCC_ALIGN_BIT];
         acq_time_select <= pwdata[`ADCC_ACQ_LSB +: 3];
         conv_clock_select <= pwdata[2:0];
      end
   end

   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         acq_cnt <= 5'h00;
         dly_cnt <= 3'h0;
      end else if (!converter_on) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (go_req) begin
                  state <= rc_sel ? ST_RC_DLY : ST_ACQ;
                  acq_cnt <= acq_periods(acq_time_select);
                  dly_cnt <= 3'(`ADCC_INSTR_CYCLES - 1);
               end
            end
            ST_RC_DLY: begin
               if (dly_cnt == 3'h0) begin
                  state <= ST_ACQ;
               end else begin
                  dly_cnt <= dly_cnt - 3'h1;
               end
            end
            ST_ACQ: begin
               if (acq_cnt == 5'h00) begin
                  state <= ST_CONV;
               end else if (conv.tad) begin
                  acq_cnt <= acq_cnt - 5'h01;
               end
            end
            ST_CONV: begin
               if (conv.done) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign converter_enable = converter_on;
   assign sampling = converter_on && (state == ST_RC_DLY || state == ST_ACQ);
   assign conv.start = (state == ST_ACQ) && (acq_cnt == 5'h00) && converter_on;
   assign conv.abort = !converter_on;
   assign conv.cmp_above = cmp_above;
   assign dac_code = conv.dac_code;

   adcc_tad_gen u_tad (
      .pclk(pclk),
      .presetn(presetn),
      .enable(converter_on && (state == ST_ACQ || state == ST_CONV)),
      .clk_sel(conv_clock_select),
      .rc_tick(rc_tick),
      .tad(conv.tad)
   );

   adcc_sar u_sar (
      .pclk(pclk),
      .presetn(presetn),
      .conv(conv.sar)
   );

   // result registers, justified at load time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_high <= 8'h00;
         result_low <= 8'h00;
      end else if (conv.done && converter_on) begin
         if (result_align) begin
            result_high <= {6'h00, conv.result[9:8]};
            result_low <= conv.result[7:0];
         end else begin
            result_high <= conv.result[9:2];
            result_low <= {conv.result[1:0], 6'h00};
         end
      end
   end

   // completion flag: write 1 clears, a new completion wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_complete_flag <= 1'b0;
      end else if (conv.done && converter_on) begin
         conv_complete_flag <= 1'b1;
      end else if (wr && paddr == `ADCC_OFF_FLAG && pwdata[`ADCC_FLAG_BIT]) begin
         conv_complete_flag <= 1'b0;
      end
   end

   // read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `ADCC_OFF_MAIN: prdata[5:0] <= {channel_select, busy, converter_on};
            `ADCC_OFF_PORT: prdata[5:0] <= {neg_ref_select, pos_ref_select,
               pin_analog_config};
            `ADCC_OFF_TIMING: prdata[7:0] <= {result_align, 1'b0, acq_time_select,
               conv_clock_select};
            `ADCC_OFF_RES_HI: prdata[7:0] <= result_high;
            `ADCC_OFF_RES_LO: prdata[7:0] <= result_low;
            `ADCC_OFF_FLAG: prdata[0] <= conv_complete_flag;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   a_off_forces_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      !converter_on |=> state == ST_IDLE && !conv.start)
      else $error("converter off but sequencer active");

   a_neg_ref_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `ADCC_OFF_PORT && por_loaded) |=> neg_ref_select == $past(pwdata[5]))
      else $error("negative reference select not taken");

   a_pos_ref_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `ADCC_OFF_PORT && por_loaded) |=> pos_ref_select == $past(pwdata[4]))
      else $error("positive reference select not taken");

   a_pin_map_ends: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pin_analog_config <= 4'h2 |-> analog_pin_mask == 13'h1FFF)
      and (pin_analog_config == 4'h3 |-> analog_pin_mask == 13'h0FFF)
      and (pin_analog_config == 4'hF |-> analog_pin_mask == 13'h0000))
      else $error("pin analog map wrong");

   a_por_fuse_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      !por_loaded |=> pin_analog_config == ($past(portb_analog_default_fuse) ? 4'h0 : 4'h7))
      else $error("power-on pin field not loaded from fuse");

   a_unimpl_read_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && paddr == `ADCC_OFF_TIMING) |=> prdata[6] == 1'b0 && prdata[31:8] == 24'h0)
      else $error("unimplemented bit reads nonzero");

   a_right_align: assert property (
      @(posedge pclk) disable iff (!presetn)
      (conv.done && converter_on && result_align) |=> result_high[7:2] == 6'h00
         && result_low == $past(conv.result[7:0]))
      else $error("right-justified result wrong");

   a_acq_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      (go_req && !rc_sel && acq_time_select == 3'h7) |=> state == ST_ACQ && acq_cnt == 5'h14)
      else $error("acquisition length not loaded");

   a_rc_delay: assert property (
      @(posedge pclk) disable iff (!presetn || !converter_on)
      (go_req && rc_sel) |=> (state == ST_RC_DLY) [*4] ##1 state == ST_ACQ)
      else $error("rc start delay not one instruction cycle");

   a_go_reads_busy: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && paddr == `ADCC_OFF_MAIN) |=> prdata[1] == $past(busy))
      else $error("go bit does not show busy");

   a_done_effects: assert property (
      @(posedge pclk) disable iff (!presetn)
      (conv.done && converter_on) |=> conv_complete_flag && state == ST_IDLE)
      else $error("completion did not set flag and clear go");

   a_auto_convert: assert property (
      @(posedge pclk) disable iff (!presetn || !converter_on)
      (state == ST_ACQ && acq_cnt == 5'h00) |-> conv.start ##1 state == ST_CONV)
      else $error("conversion did not start after acquisition");

   a_channel_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `ADCC_OFF_MAIN) |=> channel_select == $past(pwdata[5:2]))
      else $error("channel select not taken");
endmodule

/* File: tb/adcc_ctrl_bench.sv */
// self-checking bench for the converter control block: apb tasks and scenarios
// assumes: design files compiled first; comparator and rc oscillator are modelled here
`timescale 1ns/1ns
`include "adcc_params.svh"
module adcc_ctrl_bench
   import adcc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic portb_analog_default_fuse, rc_tick, cmp_above;
   logic converter_enable, sampling, neg_ref_select, pos_ref_select, conv_complete_flag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] dac_code, vin;
   logic [3:0] channel_select;
   logic [12:0] analog_pin_mask;
   logic [2:0] rc_cnt;
   int err_count, n_checks, cyc;
   int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int div_tab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   logic [9:0] vin_tab[8] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h001, 10'h200, 10'h1FF,
      10'h0F0};

   adcc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .portb_analog_default_fuse(portb_analog_default_fuse),
      .rc_tick(rc_tick), .cmp_above(cmp_above), .dac_code(dac_code),
      .converter_enable(converter_enable), .sampling(sampling),
      .channel_select(channel_select), .neg_ref_select(neg_ref_select),
      .pos_ref_select(pos_ref_select), .analog_pin_mask(analog_pin_mask),
      .conv_complete_flag(conv_complete_flag));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // rc oscillator tick every 8 cycles
   always @(posedge pclk) begin
      rc_cnt <= rc_cnt + 3'h1;
      rc_tick <= (rc_cnt == 3'h7);
   end

   // analog comparator: follows the trial code without a clock of delay
   assign cmp_above = (dac_code <= vin);

   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         $display("timeout after %0d cycles", cyc);
         complete_run;
      end
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) err_count++;
   endtask

   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask

   task do_reset(input logic f);
      portb_analog_default_fuse <= f;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   function automatic logic [12:0] mask_of(input int c);
      if (c <= 2) return 13'h1FFF;
      return 13'((1 << (15 - c)) - 1);
   endfunction

   task run_conv(input int i);
      int n, dv, lo, hi;
      logic [9:0] v;
      dv = div_tab[i];
      v = vin_tab[i];
      vin <= v;
      apb(1'b1, `ADCC_OFF_TIMING, 32'((i % 2) * 128 + (i * 8) + i));
      apb(1'b1, `ADCC_OFF_MAIN, 32'(((i + 5) << 2) + 1));
      apb(1'b1, `ADCC_OFF_MAIN, 32'(((i + 5) << 2) + 3));
      n = 0;
      @(negedge pclk);
      while (sampling === 1'b1 && n < 3000) begin
         n++;
         @(negedge pclk);
      end
      lo = (dv == 0) ? 4 + acq_tab[i] * 8 - 8 : acq_tab[i] * dv;
      hi = (dv == 0) ? lo + 17 : lo + dv;
      chk("acq_len", 32'(n >= lo && n <= hi), 32'h1);
      chk("channel", 32'(channel_select), 32'(i + 5));
      chk("enable", 32'(converter_enable), 32'h1);
      n = 0;
      while (conv_complete_flag !== 1'b1 && n < 3000) begin
         n++;
         @(negedge pclk);
      end
      lo = (dv == 0) ? 72 : 10 * dv;
      hi = (dv == 0) ? 100 : lo + dv + 2;
      chk("conv_len", 32'(n >= lo && n <= hi), 32'h1);
      rdchk("main_idle", `ADCC_OFF_MAIN, 32'(((i + 5) << 2) + 1));
      if (i % 2 == 1) begin
         rdchk("res_hi", `ADCC_OFF_RES_HI, {30'h0, v[9:8]});
         rdchk("res_lo", `ADCC_OFF_RES_LO, {24'h0, v[7:0]});
      end else begin
         rdchk("res_hi", `ADCC_OFF_RES_HI, {24'h0, v[9:2]});
         rdchk("res_lo", `ADCC_OFF_RES_LO, {24'h0, v[1:0], 6'h0});
      end
      rdchk("flag_set", `ADCC_OFF_FLAG, 32'h1);
      apb(1'b1, `ADCC_OFF_FLAG, 32'h1);
      rdchk("flag_clr", `ADCC_OFF_FLAG, 32'h0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      portb_analog_default_fuse = 1'b0;
      rc_tick = 1'b0;
      rc_cnt = 3'h0;
      vin = 10'h000;
      do_reset(1'b0);
      rdchk("port_fuse0", `ADCC_OFF_PORT, 32'h7);
      chk("mask_fuse0", 32'(analog_pin_mask), 32'hFF);
      rdchk("timing_rst", `ADCC_OFF_TIMING, 32'h0);
      rdchk("main_rst", `ADCC_OFF_MAIN, 32'h0);
      do_reset(1'b1);
      rdchk("port_fuse1", `ADCC_OFF_PORT, 32'h0);
      chk("mask_fuse1", 32'(analog_pin_mask), 32'h1FFF);
      $display("reset test done");
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, `ADCC_OFF_PORT, 32'((c % 4) * 16 + c));
         @(negedge pclk);
         chk("pin_mask", 32'(analog_pin_mask), 32'(mask_of(c)));
         chk("neg_ref", 32'(neg_ref_select), 32'((c >> 1) & 1));
         chk("pos_ref", 32'(pos_ref_select), 32'(c & 1));
      end
      apb(1'b1, `ADCC_OFF_PORT, 32'hFF);
      rdchk("port_unimpl", `ADCC_OFF_PORT, 32'h3F);
      apb(1'b1, `ADCC_OFF_TIMING, 32'hFF);
      rdchk("timing_unimpl", `ADCC_OFF_TIMING, 32'hBF);
      $display("config test done");
      apb(1'b1, 8'h1C, 32'hFF);
      chk("unmapped_wr_err", 32'(er), 32'h1);
      rdchk("unmapped_rd", 8'h1C, 32'h0);
      chk("unmapped_rd_err", 32'(er), 32'h1);
      apb(1'b1, `ADCC_OFF_MAIN, 32'h2);
      @(negedge pclk);
      chk("go_off_sampling", 32'(sampling), 32'h0);
      chk("go_off_enable", 32'(converter_enable), 32'h0);
      rdchk("go_off_main", `ADCC_OFF_MAIN, 32'h0);
      $display("bus test done");
      for (int i = 0; i < 8; i++) run_conv(i);
      apb(1'b1, `ADCC_OFF_RES_LO, 32'hFF);
      rdchk("res_ro", `ADCC_OFF_RES_LO, {24'h0, vin_tab[7][7:0]});
      $display("conversion test done");
      apb(1'b1, `ADCC_OFF_TIMING, 32'h3E);
      apb(1'b1, `ADCC_OFF_MAIN, 32'h1);
      apb(1'b1, `ADCC_OFF_MAIN, 32'h3);
      repeat (100) @(posedge pclk);
      rdchk("busy", `ADCC_OFF_MAIN, 32'h3);
      apb(1'b1, `ADCC_OFF_MAIN, 32'h0);
      @(negedge pclk);
      chk("abort_enable", 32'(converter_enable), 32'h0);
      chk("abort_sampling", 32'(sampling), 32'h0);
      repeat (2100) @(posedge pclk);
      chk("abort_flag", 32'(conv_complete_flag), 32'h0);
      rdchk("abort_main", `ADCC_OFF_MAIN, 32'h0);
      $display("abort test done");
      complete_run;
   end
endmodule
